//--- hdl/cmd_pin_pkg.sv
// Package of constants and carrier types for the memory command pin front end
package cmd_pin_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned COL_W = 10;
  localparam int unsigned NUM_BANKS = 8;
  // ==========================================================================
  // Address bit positions
  localparam int unsigned AUTO_PRECHARGE_POS = 10;
  localparam int unsigned BURST_CHOP_POS = 12;
  localparam int unsigned TERM_STROBE_POS = 11;
  // Mode register index and reset values
  localparam logic [2:0] SECOND_MODE_REG_IDX = 3'h1;
  localparam logic [15:0] MODE_REG_RESET = 16'h0000;
  // Bits of the second mode register that select termination value (zero = off)
  localparam int unsigned TERM_RTT_POS0 = 2;
  localparam int unsigned TERM_RTT_POS1 = 6;
  localparam int unsigned TERM_RTT_POS2 = 9;
  // ==========================================================================
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CODE_MODE_SET = 4'h0;
  localparam logic [3:0] CODE_REFRESH = 4'h1;
  localparam logic [3:0] CODE_PRECHARGE = 4'h2;
  localparam logic [3:0] CODE_ACTIVATE = 4'h3;
  localparam logic [3:0] CODE_WRITE = 4'h4;
  localparam logic [3:0] CODE_READ = 4'h5;
  localparam logic [3:0] CODE_ZQ = 4'h6;
  localparam logic [3:0] CODE_NOP = 4'h7;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
    CMD_WRITE, CMD_READ, CMD_ZQ, CMD_NOP
  } cmd_t;

  // Pins as sampled at the clock crossing
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
    logic termination_request;
  } pin_sample_t;

  // Decoded command handed to the core
  typedef struct packed {
    cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic auto_precharge;
    logic precharge_all;
    logic burst_chop;
    logic [2:0] mode_reg_idx;
    logic [ADDR_W-1:0] opcode;
  } cmd_info_t;
endpackage : cmd_pin_pkg

//--- hdl/cmd_pin_decode.sv
// Command decoder: turns one sampled pin set into a command record
`timescale 1ns/100ps
`default_nettype none
module cmd_pin_decode (
  // Sampled pins
  input wire cmd_pin_pkg::pin_sample_t pins,
  // Decoded command
  output cmd_pin_pkg::cmd_info_t info
);
  // ==========================================================================
  // Decode
  always_comb begin
    info = '0;
    info.bank = pins.bank_select;
    info.row = pins.addr[cmd_pin_pkg::ROW_W-1:0];
    info.col = pins.addr[cmd_pin_pkg::COL_W-1:0];
    info.auto_precharge = pins.addr[cmd_pin_pkg::AUTO_PRECHARGE_POS];
    info.precharge_all = pins.addr[cmd_pin_pkg::AUTO_PRECHARGE_POS];
    info.burst_chop = ~pins.addr[cmd_pin_pkg::BURST_CHOP_POS];
    info.mode_reg_idx = pins.bank_select;
    info.opcode = pins.addr;
    // Chip select high masks the whole command
    if (pins.cs_n) begin
      info.cmd = cmd_pin_pkg::CMD_NONE;
    end else begin
      unique case ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n})
        cmd_pin_pkg::CODE_MODE_SET: info.cmd = cmd_pin_pkg::CMD_MODE_SET;
        cmd_pin_pkg::CODE_REFRESH: info.cmd = cmd_pin_pkg::CMD_REFRESH;
        cmd_pin_pkg::CODE_PRECHARGE: info.cmd = cmd_pin_pkg::CMD_PRECHARGE;
        cmd_pin_pkg::CODE_ACTIVATE: info.cmd = cmd_pin_pkg::CMD_ACTIVATE;
        cmd_pin_pkg::CODE_WRITE: info.cmd = cmd_pin_pkg::CMD_WRITE;
        cmd_pin_pkg::CODE_READ: info.cmd = cmd_pin_pkg::CMD_READ;
        cmd_pin_pkg::CODE_ZQ: info.cmd = cmd_pin_pkg::CMD_ZQ;
        default: info.cmd = cmd_pin_pkg::CMD_NOP;
      endcase
    end
  end
endmodule : cmd_pin_decode
`default_nettype wire

//--- hdl/cmd_pin_front.sv
// Command and control pin front end of a x16 double-data-rate memory device
//
// Overview of operation
// - All control and address pins are captured on the true-clock rising crossing.
// - Clock enable high runs clocks, buffers and drivers; low stops clocks and command buffers.
// - Clock enable low: idle banks give precharge power-down or self-refresh, else active.
// - Self-refresh exits on clock enable rising, seen without a clock edge.
// - Power-down keeps only clock, termination request and clock enable buffers on.
// - Self-refresh keeps only the clock enable buffer on.
// - Commands with chip select registered high are ignored.
// - Command decoded from chip select, row, column and write strobes together.
// - Registered termination request enables termination on data, strobes and masks.
// - Termination request ignored when second mode register disables termination.
// - Write beats with their mask sampled high are discarded, both strobe edges; the code samples the mask once per beat on the core clock rising edge.
// - On x8 a second mode register bit picks data mask or termination strobe.
// - Bank select picks target bank of activate, read, write, precharge.
// - Bank select picks which mode register a mode set writes; only the second mode register is held here.
// - Address gives row on activate and column on read and write.
// - Address inputs give the op-code of a mode register set.
// - Auto-precharge bit high closes the bank after a read or write.
// - Precharge with auto-precharge bit high closes all banks, else one bank.
// - Burst-chop bit low chops the burst; high runs full burst.
// - Reset input is active low and asynchronous.
`timescale 1ns/100ps
`default_nettype none
module cmd_pin_front (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Command and address pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [cmd_pin_pkg::BANK_W-1:0] bank_select,
  input wire logic [cmd_pin_pkg::ADDR_W-1:0] addr,
  input wire logic termination_request,
  // Write mask pins, one per byte lane, sampled by the data path per beat
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic beat_valid,
  // Decoded command toward the array
  output logic cmd_valid,
  output cmd_pin_pkg::cmd_info_t cmd_info,
  // Power and buffer state
  output logic clocks_on,
  output logic cmd_buffers_on,
  output logic term_buffer_on,
  output logic precharge_power_down,
  output logic active_power_down,
  output logic self_refresh,
  // Bank and termination state
  output logic [cmd_pin_pkg::NUM_BANKS-1:0] bank_open,
  output logic termination_on,
  output logic [1:0] byte_write_enable,
  output logic termination_strobe_mode
);
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} pwr_t;

  // ==========================================================================
  // Input synchroniser: two flops before any logic
  cmd_pin_pkg::pin_sample_t raw_s;
  cmd_pin_pkg::pin_sample_t meta_q;
  cmd_pin_pkg::pin_sample_t samp_q;
  logic [2:0] mask_meta_q;
  logic [2:0] mask_q;
  cmd_pin_pkg::cmd_info_t dec_s;

  assign raw_s = '{cke: cke, cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
                   bank_select: bank_select, addr: addr, termination_request: termination_request};

  // Sample on the core clock rising edge, standing for the differential crossing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      samp_q <= '0;
      mask_meta_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      meta_q <= raw_s;
      samp_q <= meta_q;
      mask_meta_q <= {beat_valid, upper_byte_mask, lower_byte_mask};
      mask_q <= mask_meta_q;
    end
  end

  cmd_pin_decode u_decode (
    .pins(samp_q),
    .info(dec_s)
  );

  // ==========================================================================
  // Power state, mode register, bank state
  pwr_t pwr_q, pwr_d;
  logic [cmd_pin_pkg::ADDR_W-1:0] mode_reg_q, mode_reg_d;
  logic [cmd_pin_pkg::NUM_BANKS-1:0] bank_open_q, bank_open_d;
  logic cmd_valid_q, cmd_valid_d;
  cmd_pin_pkg::cmd_info_t cmd_info_q, cmd_info_d;
  logic term_on_q, term_on_d;
  logic [1:0] bwe_q, bwe_d;
  logic cmd_live;
  logic term_enabled;

  // Commands are accepted only while clocks and command buffers run
  assign cmd_live = (pwr_q == PWR_ACTIVE) && samp_q.cke;
  // Any nonzero termination value in the second mode register enables it
  assign term_enabled = mode_reg_q[cmd_pin_pkg::TERM_RTT_POS0] | mode_reg_q[cmd_pin_pkg::TERM_RTT_POS1] |
                        mode_reg_q[cmd_pin_pkg::TERM_RTT_POS2];

  // Next-state logic for power, banks, mode register and termination
  always_comb begin
    pwr_d = pwr_q;
    mode_reg_d = mode_reg_q;
    bank_open_d = bank_open_q;
    cmd_valid_d = 1'b0;
    cmd_info_d = cmd_info_q;
    term_on_d = 1'b0;
    bwe_d = 2'h0;
    unique case (pwr_q)
      PWR_ACTIVE: begin
        if (!samp_q.cke) begin
          // A refresh issued with clock enable dropping and all banks idle enters self-refresh
          if (bank_open_q == '0) begin
            pwr_d = (dec_s.cmd == cmd_pin_pkg::CMD_REFRESH) ? PWR_SELF_REF : PWR_PRE_PD;
          end else begin
            pwr_d = PWR_ACT_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD: begin
        if (samp_q.cke) begin
          pwr_d = PWR_ACTIVE;
        end
      end
      PWR_SELF_REF: begin
        // Exit waits for the synchronised clock enable; outputs wake early on the asynchronous path below
        if (samp_q.cke) begin
          pwr_d = PWR_ACTIVE;
        end
      end
    endcase
    if (cmd_live && dec_s.cmd != cmd_pin_pkg::CMD_NONE && dec_s.cmd != cmd_pin_pkg::CMD_NOP) begin
      cmd_valid_d = 1'b1;
      cmd_info_d = dec_s;
      unique case (dec_s.cmd)
        cmd_pin_pkg::CMD_ACTIVATE: bank_open_d[dec_s.bank] = 1'b1;
        cmd_pin_pkg::CMD_PRECHARGE: begin
          if (dec_s.precharge_all) begin
            bank_open_d = '0;
          end else begin
            bank_open_d[dec_s.bank] = 1'b0;
          end
        end
        cmd_pin_pkg::CMD_READ, cmd_pin_pkg::CMD_WRITE: begin
          if (dec_s.auto_precharge) begin
            bank_open_d[dec_s.bank] = 1'b0;
          end
        end
        cmd_pin_pkg::CMD_MODE_SET: begin
          if (dec_s.mode_reg_idx == cmd_pin_pkg::SECOND_MODE_REG_IDX) begin
            mode_reg_d = dec_s.opcode;
          end
        end
        default: ;
      endcase
    end
    // Termination request stays sampled in power-down but not in self-refresh
    term_on_d = samp_q.termination_request && term_enabled && (pwr_q != PWR_SELF_REF);
    // A high mask on a beat blocks that byte lane while commands are live; the strobe mode bit does not gate the mask
    if (mask_q[2] && cmd_live) begin
      bwe_d[1] = ~mask_q[1];
      bwe_d[0] = ~mask_q[0];
    end
  end

  // Register the state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_ACTIVE;
      mode_reg_q <= cmd_pin_pkg::MODE_REG_RESET;
      bank_open_q <= '0;
      cmd_valid_q <= 1'b0;
      cmd_info_q <= '0;
      term_on_q <= 1'b0;
      bwe_q <= 2'h0;
    end else begin
      pwr_q <= pwr_d;
      mode_reg_q <= mode_reg_d;
      bank_open_q <= bank_open_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_info_q <= cmd_info_d;
      term_on_q <= term_on_d;
      bwe_q <= bwe_d;
    end
  end

  // ==========================================================================
  // Self-refresh exit: clock enable rise is seen without a clock edge.
  // The raw pin is only gated with the registered state; this is an
  // asynchronous wake path, so it may glitch briefly on entry.
  logic sr_wake;
  assign sr_wake = (pwr_q == PWR_SELF_REF) && cke;

  // ==========================================================================
  // Outputs
  assign cmd_valid = cmd_valid_q;
  assign cmd_info = cmd_info_q;
  assign clocks_on = ((pwr_q == PWR_ACTIVE) && samp_q.cke) || sr_wake;
  assign cmd_buffers_on = clocks_on;
  assign term_buffer_on = (pwr_q != PWR_SELF_REF) || sr_wake;
  assign precharge_power_down = (pwr_q == PWR_PRE_PD);
  assign active_power_down = (pwr_q == PWR_ACT_PD);
  assign self_refresh = (pwr_q == PWR_SELF_REF) && !sr_wake;
  assign bank_open = bank_open_q;
  assign termination_on = term_on_q;
  assign byte_write_enable = bwe_q;
  assign termination_strobe_mode = mode_reg_q[cmd_pin_pkg::TERM_STROBE_POS];

  // ==========================================================================
  // Assertions
  property p_mask_chip_select;
    @(posedge core_clk) disable iff (!rst_n) samp_q.cs_n |=> !cmd_valid;
  endproperty
  a_mask_chip_select: assert property (p_mask_chip_select) else $error("command taken with chip select high");

  property p_precharge_all;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_live && dec_s.cmd == cmd_pin_pkg::CMD_PRECHARGE && dec_s.precharge_all) |=> (bank_open == '0);
  endproperty
  a_precharge_all: assert property (p_precharge_all) else $error("precharge all left a bank open");

  property p_activate_opens;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_live && dec_s.cmd == cmd_pin_pkg::CMD_ACTIVATE) |=> bank_open[$past(dec_s.bank)];
  endproperty
  a_activate_opens: assert property (p_activate_opens) else $error("activate did not open bank");

  property p_auto_precharge;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_live && dec_s.cmd == cmd_pin_pkg::CMD_READ && dec_s.auto_precharge) |=> !bank_open[$past(dec_s.bank)];
  endproperty
  a_auto_precharge: assert property (p_auto_precharge) else $error("auto precharge did not close bank");

  property p_term_disabled;
    @(posedge core_clk) disable iff (!rst_n) !term_enabled |=> !termination_on;
  endproperty
  a_term_disabled: assert property (p_term_disabled) else $error("termination on while disabled");

  property p_power_down_kind;
    @(posedge core_clk) disable iff (!rst_n)
      (pwr_q == PWR_ACTIVE && !samp_q.cke && bank_open != '0) |=> active_power_down;
  endproperty
  a_power_down_kind: assert property (p_power_down_kind) else $error("wrong power-down kind");

  property p_cke_gates;
    @(posedge core_clk) disable iff (!rst_n) precharge_power_down |-> !clocks_on && term_buffer_on;
  endproperty
  a_cke_gates: assert property (p_cke_gates) else $error("buffers wrong in power-down");

  property p_write_mask;
    @(posedge core_clk) disable iff (!rst_n) (mask_q[2] && mask_q[0] && cmd_live) |=> !byte_write_enable[0];
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("masked beat written");

  property p_cmd_needs_cke;
    @(posedge core_clk) disable iff (!rst_n) !cmd_live |=> !cmd_valid;
  endproperty
  a_cmd_needs_cke: assert property (p_cmd_needs_cke) else $error("command taken with clocks off");

  property p_sr_entry;
    @(posedge core_clk) disable iff (!rst_n)
      (pwr_q == PWR_ACTIVE && !samp_q.cke && bank_open == '0 &&
       dec_s.cmd == cmd_pin_pkg::CMD_REFRESH) |=> (pwr_q == PWR_SELF_REF);
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self-refresh not entered");

  property p_sr_wake;
    @(posedge core_clk) disable iff (!rst_n)
      (pwr_q == PWR_SELF_REF && cke) |-> (!self_refresh && clocks_on);
  endproperty
  a_sr_wake: assert property (p_sr_wake) else $error("self-refresh wake missed");

  property p_sr_bufs;
    @(posedge core_clk) disable iff (!rst_n) self_refresh |-> (!cmd_buffers_on && !term_buffer_on);
  endproperty
  a_sr_bufs: assert property (p_sr_bufs) else $error("buffers on in self-refresh");

  property p_apd_bufs;
    @(posedge core_clk) disable iff (!rst_n) active_power_down |-> (!cmd_buffers_on && term_buffer_on);
  endproperty
  a_apd_bufs: assert property (p_apd_bufs) else $error("buffers wrong in active power-down");

  property p_term_follows;
    @(posedge core_clk) disable iff (!rst_n)
      (samp_q.termination_request && term_enabled && pwr_q != PWR_SELF_REF) |=> termination_on;
  endproperty
  a_term_follows: assert property (p_term_follows) else $error("termination request not honoured");

  property p_mode_load;
    @(posedge core_clk) disable iff (!rst_n)
      (cmd_live && dec_s.cmd == cmd_pin_pkg::CMD_MODE_SET &&
       dec_s.mode_reg_idx == cmd_pin_pkg::SECOND_MODE_REG_IDX)
        |=> (mode_reg_q == $past(dec_s.opcode));
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode register op-code not loaded");
endmodule : cmd_pin_front
`default_nettype wire

//--- test/cmd_ctrl_model.sv
// Behavioural model of the memory controller that drives the command pins
`timescale 1ns/100ps
`default_nettype none
module cmd_ctrl_model (
  // Clock and bench requests
  input wire logic core_clk,
  input wire logic boot_rst_n,
  input wire logic access_busy,
  input wire cmd_pin_pkg::pin_sample_t want,
  // Pins toward the device
  output logic rst_n,
  output cmd_pin_pkg::pin_sample_t pins
);
  // ==========================================================================
  // Pin registers
  cmd_pin_pkg::pin_sample_t pins_q = {1'b0, 4'hf, 20'h00000};
  cmd_pin_pkg::pin_sample_t pins_d;

  // Reset only drops when the bench asks for it
  assign rst_n = boot_rst_n;

  // Next pin values, with the controller's own obligations applied
  always_comb begin
    pins_d = want;
    if (access_busy) begin
      pins_d.cke = 1'b1;
    end
    if (want.cs_n == 1'b0 && {want.ras_n, want.cas_n, want.we_n} == 3'h0 &&
        want.bank_select == cmd_pin_pkg::SECOND_MODE_REG_IDX) begin
      pins_d.addr[cmd_pin_pkg::TERM_STROBE_POS] = 1'b0;
    end
    // Deselected address lines wander, so a stale value never looks valid
    if (want.cs_n) begin
      pins_d.addr = ~pins_q.addr;
      pins_d.bank_select = ~pins_q.bank_select;
    end
  end

  // Launch on the rising edge, like a real controller
  always_ff @(posedge core_clk) begin
    pins_q <= pins_d;
  end
  assign pins = pins_q;
endmodule : cmd_ctrl_model
`default_nettype wire

//--- test/ddr3_dram_pin_command_control_tb.sv
// Self-checking bench for the command pin front end
`timescale 1ns/100ps
`default_nettype none
module ddr3_dram_pin_command_control_tb;
  // ==========================================================================
  // Signals
  logic core_clk = 1'b0;
  logic boot_rst_n = 1'b0;
  logic access_busy = 1'b0;
  logic rst_n;
  logic upper_byte_mask = 1'b0;
  logic lower_byte_mask = 1'b0;
  logic beat_valid = 1'b0;
  cmd_pin_pkg::pin_sample_t want = {1'b0, 4'hf, 20'h00000};
  cmd_pin_pkg::pin_sample_t pins;
  logic cmd_valid, clocks_on, cmd_buffers_on, term_buffer_on;
  logic precharge_power_down, active_power_down, self_refresh;
  logic termination_on, termination_strobe_mode;
  logic [1:0] byte_write_enable;
  logic [cmd_pin_pkg::NUM_BANKS-1:0] bank_open;
  cmd_pin_pkg::cmd_info_t cmd_info;
  int err_total = 0;
  int n_compared = 0;
  logic seen;
  logic [15:0] a;
  logic [2:0] b;

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end

  always #2 core_clk = ~core_clk;

  // ==========================================================================
  // Partner and device
  cmd_ctrl_model ctrl (.core_clk(core_clk), .boot_rst_n(boot_rst_n), .access_busy(access_busy),
    .want(want), .rst_n(rst_n), .pins(pins));
  cmd_pin_front dut (.core_clk(core_clk), .rst_n(rst_n), .cke(pins.cke), .cs_n(pins.cs_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .bank_select(pins.bank_select),
    .addr(pins.addr), .termination_request(pins.termination_request),
    .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask), .beat_valid(beat_valid),
    .cmd_valid(cmd_valid), .cmd_info(cmd_info), .clocks_on(clocks_on), .cmd_buffers_on(cmd_buffers_on),
    .term_buffer_on(term_buffer_on), .precharge_power_down(precharge_power_down),
    .active_power_down(active_power_down), .self_refresh(self_refresh), .bank_open(bank_open),
    .termination_on(termination_on), .byte_write_enable(byte_write_enable),
    .termination_strobe_mode(termination_strobe_mode));

  // ==========================================================================
  // Expectation helpers
  function automatic cmd_pin_pkg::cmd_t exp_cmd(input logic [3:0] code);
    case (code)
      cmd_pin_pkg::CODE_ACTIVATE: exp_cmd = cmd_pin_pkg::CMD_ACTIVATE;
      cmd_pin_pkg::CODE_READ: exp_cmd = cmd_pin_pkg::CMD_READ;
      cmd_pin_pkg::CODE_WRITE: exp_cmd = cmd_pin_pkg::CMD_WRITE;
      cmd_pin_pkg::CODE_PRECHARGE: exp_cmd = cmd_pin_pkg::CMD_PRECHARGE;
      default: exp_cmd = cmd_pin_pkg::CMD_MODE_SET;
    endcase
  endfunction : exp_cmd

  // ==========================================================================
  // Bus tasks: one command cycle, then deselect
  task automatic issue(input logic [3:0] code, input logic [2:0] bk, input logic [15:0] ad);
    @(posedge core_clk);
    {want.cs_n, want.ras_n, want.cas_n, want.we_n} <= code;
    want.bank_select <= bk;
    want.addr <= ad;
    @(posedge core_clk);
    {want.cs_n, want.ras_n, want.cas_n, want.we_n} <= 4'hf;
  endtask : issue

  // Bounded wait for the accept pulse, sampled after each edge settles
  task automatic wait_cmd();
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge core_clk);
      #1;
      seen = (cmd_valid === 1'b1);
    end
  endtask : wait_cmd

  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    err_total++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(65));
    repeat (3) @(posedge core_clk);
    boot_rst_n <= 1'b1;
    want.cke <= 1'b1;
    settle();
    `CHK("bank_open", 8'h00, bank_open)
    `CHK("clocks_on", 1'b1, clocks_on)
    // Activate then random-address write (even bank) or read (odd bank) on every bank
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom());
      issue(cmd_pin_pkg::CODE_ACTIVATE, 3'(i), a);
      wait_cmd();
      `CHK("act_seen", 1'b1, seen)
      `CHK("act_cmd", cmd_pin_pkg::CMD_ACTIVATE, cmd_info.cmd)
      `CHK("act_bank", 3'(i), cmd_info.bank)
      `CHK("act_row", a[11:0], cmd_info.row)
      `CHK("open", 1'b1, bank_open[i])
      a = 16'($urandom());
      access_busy <= 1'b1;
      issue((i % 2) ? cmd_pin_pkg::CODE_READ : cmd_pin_pkg::CODE_WRITE, 3'(i), a);
      wait_cmd();
      access_busy <= 1'b0;
      `CHK("rw_cmd", exp_cmd((i % 2) ? cmd_pin_pkg::CODE_READ : cmd_pin_pkg::CODE_WRITE), cmd_info.cmd)
      `CHK("rw_col", a[9:0], cmd_info.col)
      `CHK("rw_autopre", a[10], cmd_info.auto_precharge)
      `CHK("rw_open", ~a[10], bank_open[i])
      `CHK("rw_chop", ~a[12], cmd_info.burst_chop)
    end
    // Single bank then all-bank precharge
    issue(cmd_pin_pkg::CODE_ACTIVATE, 3'h3, 16'h0000);
    issue(cmd_pin_pkg::CODE_ACTIVATE, 3'h5, 16'h0000);
    settle();
    issue(cmd_pin_pkg::CODE_PRECHARGE, 3'h3, 16'($urandom()) & 16'hfbff);
    settle();
    `CHK("pre_one", 1'b0, cmd_info.precharge_all)
    `CHK("pre_b3", 2'h2, {bank_open[5], bank_open[3]})
    issue(cmd_pin_pkg::CODE_PRECHARGE, 3'h0, 16'h0400);
    settle();
    `CHK("pre_all", 1'b1, cmd_info.precharge_all)
    `CHK("pre_banks", 8'h00, bank_open)
    // Mode set with termination on, then off while the request stays high
    issue(cmd_pin_pkg::CODE_MODE_SET, 3'h1, 16'h0804);
    wait_cmd();
    `CHK("mset_idx", 3'h1, cmd_info.mode_reg_idx)
    `CHK("mset_op", 16'h0004, cmd_info.opcode)
    `CHK("strobe_mode", 1'b0, termination_strobe_mode)
    want.termination_request <= 1'b1;
    settle();
    `CHK("term_on", 1'b1, termination_on)
    issue(cmd_pin_pkg::CODE_MODE_SET, 3'h1, 16'h0000);
    settle();
    `CHK("term_off", 1'b0, termination_on)
    b = 3'h2 + 3'($urandom() % 5);
    a = 16'($urandom());
    issue(cmd_pin_pkg::CODE_MODE_SET, b, a);
    wait_cmd();
    `CHK("mset_idx2", b, cmd_info.mode_reg_idx)
    `CHK("mset_op2", a, cmd_info.opcode)
    // Deselected and no-operation codes are refused
    issue(4'hb, 3'h1, 16'h0000);
    wait_cmd();
    `CHK("cs_high", 1'b0, seen)
    issue(cmd_pin_pkg::CODE_NOP, 3'h1, 16'h0000);
    wait_cmd();
    `CHK("nop", 1'b0, seen)
    // Refresh and calibration codes decode while clocks run
    issue(cmd_pin_pkg::CODE_REFRESH, 3'h0, 16'h0000);
    wait_cmd();
    `CHK("ref_cmd", cmd_pin_pkg::CMD_REFRESH, cmd_info.cmd)
    issue(cmd_pin_pkg::CODE_ZQ, 3'h0, 16'h0000);
    wait_cmd();
    `CHK("zq_cmd", cmd_pin_pkg::CMD_ZQ, cmd_info.cmd)
    // Termination back on, so the power states show what they keep
    issue(cmd_pin_pkg::CODE_MODE_SET, 3'h1, 16'h0004);
    settle();
    // Active power-down, commands refused while clock enable is low
    issue(cmd_pin_pkg::CODE_ACTIVATE, 3'h0, 16'h0000);
    @(posedge core_clk);
    want.cke <= 1'b0;
    settle();
    `CHK("apd", 2'h2, {active_power_down, precharge_power_down})
    `CHK("bufs", 3'h1, {clocks_on, cmd_buffers_on, term_buffer_on})
    `CHK("pd_term", 1'b1, termination_on)
    issue(cmd_pin_pkg::CODE_ACTIVATE, 3'h4, 16'h0000);
    wait_cmd();
    `CHK("pd_cmd", 1'b0, seen)
    want.cke <= 1'b1;
    settle();
    `CHK("apd_exit", 1'b0, active_power_down)
    issue(cmd_pin_pkg::CODE_PRECHARGE, 3'h0, 16'h0400);
    settle();
    want.cke <= 1'b0;
    settle();
    `CHK("ppd", 2'h1, {active_power_down, precharge_power_down})
    want.cke <= 1'b1;
    settle();
    // Self-refresh entry with refresh and clock enable low together
    {want.cs_n, want.ras_n, want.cas_n, want.we_n} <= cmd_pin_pkg::CODE_REFRESH;
    want.cke <= 1'b0;
    @(posedge core_clk);
    {want.cs_n, want.ras_n, want.cas_n, want.we_n} <= 4'hf;
    settle();
    `CHK("sr", 1'b1, self_refresh)
    `CHK("sr_bufs", 2'h0, {cmd_buffers_on, term_buffer_on})
    `CHK("sr_term", 1'b0, termination_on)
    want.cke <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK("sr_exit", 1'b0, self_refresh)
    settle();
    // Write masks, every combination plus random
    for (int m = 0; m < 6; m++) begin
      @(posedge core_clk);
      beat_valid <= 1'b1;
      {upper_byte_mask, lower_byte_mask} <= (m < 4) ? 2'(m) : 2'($urandom());
      @(posedge core_clk);
      beat_valid <= 1'b0;
      a[1:0] = ~{upper_byte_mask, lower_byte_mask};
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("bwe", a[1:0], byte_write_enable)
    end
    // Asynchronous reset in mid-run
    issue(cmd_pin_pkg::CODE_ACTIVATE, 3'h6, 16'h0000);
    settle();
    @(posedge core_clk);
    boot_rst_n <= 1'b0;
    #1;
    `CHK("rst_banks", 8'h00, bank_open)
    repeat (2) @(posedge core_clk);
    boot_rst_n <= 1'b1;
    // Nothing may be taken in the first edges after release
    repeat (2) begin
      @(posedge core_clk);
      #1;
      `CHK("rst_quiet", 1'b0, cmd_valid)
    end
    settle();
    issue(cmd_pin_pkg::CODE_ACTIVATE, 3'h2, 16'h0000);
    wait_cmd();
    `CHK("rst_act", 8'h04, bank_open)
    end_sim();
  end
`undef CHK
endmodule : ddr3_dram_pin_command_control_tb
`default_nettype wire
